// ==== rtl/etm_regs.svh ====
`ifndef ETM_REGS_SVH
`define ETM_REGS_SVH

`define ETM_ADDR_W        4
`define ETM_OFS_CTRL_A    4'h0
`define ETM_OFS_CTRL_B    4'h1
`define ETM_OFS_COUNT     4'h2
`define ETM_OFS_CMP_A     4'h3
`define ETM_OFS_CMP_B     4'h4
`define ETM_OFS_IRQ_MASK  4'h5
`define ETM_OFS_IRQ_FLAGS 4'h6
`define ETM_OFS_STATUS    4'h7

`define ETM_BIT_OVF       0
`define ETM_BIT_MATCH_A   1
`define ETM_BIT_MATCH_B   2

`define ETM_BOTTOM        8'h00
`define ETM_MAX           8'hFF
`define ETM_RESET_BYTE    8'h00
`define ETM_PRESC_W       10

`endif

// ==== rtl/etm_pkg.sv ====
package etm_pkg;

    typedef enum logic [2:0] {
        ETM_CS_STOP, ETM_CS_DIV1, ETM_CS_DIV8, ETM_CS_DIV64,
        ETM_CS_DIV256, ETM_CS_DIV1024, ETM_CS_EXT_FALL, ETM_CS_EXT_RISE
    } etm_clk_sel_e;

    typedef enum logic [2:0] {
        ETM_WG_NORMAL, ETM_WG_PC_MAX, ETM_WG_CTC, ETM_WG_FAST_MAX,
        ETM_WG_RSVD, ETM_WG_PC_OCRA, ETM_WG_RSVD2, ETM_WG_FAST_OCRA
    } etm_wgm_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } etm_bus_s;

    typedef struct packed {
        logic ovf;
        logic match_a;
        logic match_b;
    } etm_evt_s;

endpackage : etm_pkg

// ==== rtl/etm_timer.sv ====
// Notes on behaviour
// - Counter and both compare values are eight-bit registers.
// - Two independent compare units A and B, each with value and output.
// - In PWM modes compare values are written into a buffer, then loaded into the active copy.
// - Clear-on-match mode clears the counter at compare A.
// - Phase-correct PWM with variable period and a frequency-generator mode.
// - Three interrupt sources: overflow, match A, match B.
// - Every interrupt request is readable in the flag register.
// - Each request is gated by its own mask bit.
// - Timer tick comes from the prescaler or the external count pin.
// - Clock select picks the source and the active edge.
// - No source selected means the counter stays still.
// - Three-bit clock select field sits in control register B.
// - Both compare values are compared with the counter on every tick.
// - Waveform generator drives the two compare outputs from compare results.
// - A compare match sets its flag, usable as an interrupt request.
// - Counter value 0x00 is bottom.
// - Counter value 0xFF is maximum.
// - Top is 0xFF or compare A depending on mode.
// - Counter counts up or down depending on mode.
// - A software count write wins over clear or count in that cycle.
// - Match flag sets at the tick after the counter equals the compare value.
// - Match flag clears on interrupt service or on writing one.
//
// Added by the designer: the address map and strobed register access.
`include "etm_regs.svh"

module etm_timer
    import etm_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       ext_count_pin_i,
    input  wire logic       ack_ovf_i,
    input  wire logic       ack_match_a_i,
    input  wire logic       ack_match_b_i,
    output logic            irq_ovf_o,
    output logic            irq_match_a_o,
    output logic            irq_match_b_o,
    output logic            wave_out_a_o,
    output logic            wave_out_b_o
);

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    etm_bus_s bus;
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    logic [7:0] ctrl_a_q;
    logic [7:0] timer_control_b_q;
    logic [7:0] count_value_q,     count_value_d;
    logic [7:0] compare_value_a_q, compare_value_b_q;
    logic [7:0] buf_a_q,           buf_b_q;
    logic [2:0] timer_irq_mask_q;
    logic [2:0] timer_irq_flags_q, timer_irq_flags_d;
    logic [7:0] rdata_q;
    logic       ext_q,             dir_down_q,  block_q;
    logic       wave_a_q,          wave_b_q;
    logic [`ETM_PRESC_W-1:0] presc_q;

    wire wr_ctrl_a = bus.wr && bus.addr == `ETM_OFS_CTRL_A;
    wire wr_ctrl_b = bus.wr && bus.addr == `ETM_OFS_CTRL_B;
    wire wr_count  = bus.wr && bus.addr == `ETM_OFS_COUNT;
    wire wr_cmp_a  = bus.wr && bus.addr == `ETM_OFS_CMP_A;
    wire wr_cmp_b  = bus.wr && bus.addr == `ETM_OFS_CMP_B;
    wire wr_mask   = bus.wr && bus.addr == `ETM_OFS_IRQ_MASK;
    wire wr_flags  = bus.wr && bus.addr == `ETM_OFS_IRQ_FLAGS;

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    etm_clk_sel_e clock_select_field;
    etm_wgm_e     wgm;
    assign clock_select_field = etm_clk_sel_e'(timer_control_b_q[2:0]);
    assign wgm = etm_wgm_e'({timer_control_b_q[3], ctrl_a_q[1:0]});
    wire [1:0] com_a = ctrl_a_q[7:6];
    wire [1:0] com_b = ctrl_a_q[5:4];
    wire force_a = wr_ctrl_b && wdata_i[7];
    wire force_b = wr_ctrl_b && wdata_i[6];

    wire is_pc   = wgm == ETM_WG_PC_MAX   || wgm == ETM_WG_PC_OCRA;
    wire is_fast = wgm == ETM_WG_FAST_MAX || wgm == ETM_WG_FAST_OCRA;
    wire is_pwm  = is_pc || is_fast;
    wire top_is_a = wgm == ETM_WG_CTC || wgm == ETM_WG_PC_OCRA
                 || wgm == ETM_WG_FAST_OCRA;
    wire [7:0] top_val = top_is_a ? compare_value_a_q : `ETM_MAX;

    // ---------------------------------------------------------------
    // Timer tick
    // ---------------------------------------------------------------
    function automatic logic presc_hit(input logic [`ETM_PRESC_W-1:0] p, input int lsb);
        presc_hit = (p & ((`ETM_PRESC_W'(1) << lsb) - `ETM_PRESC_W'(1))) == '0;
    endfunction : presc_hit

    logic timer_tick;
    always_comb begin
        unique case (clock_select_field)
            ETM_CS_STOP:     timer_tick = 1'b0;
            ETM_CS_DIV1:     timer_tick = 1'b1;
            ETM_CS_DIV8:     timer_tick = presc_hit(presc_q, 3);
            ETM_CS_DIV64:    timer_tick = presc_hit(presc_q, 6);
            ETM_CS_DIV256:   timer_tick = presc_hit(presc_q, 8);
            ETM_CS_DIV1024:  timer_tick = presc_hit(presc_q, 10);
            ETM_CS_EXT_FALL: timer_tick = ext_q && !ext_count_pin_i;
            ETM_CS_EXT_RISE: timer_tick = !ext_q && ext_count_pin_i;
        endcase
    end

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    wire at_bottom = count_value_q == `ETM_BOTTOM;
    wire at_max    = count_value_q == `ETM_MAX;
    wire at_top    = count_value_q == top_val;
    wire match_a   = count_value_q == compare_value_a_q;
    wire match_b   = count_value_q == compare_value_b_q;
    wire next_down = is_pc && (dir_down_q ? !at_bottom : at_top);

    always_comb begin
        count_value_d = count_value_q;
        if (wr_count) begin
            count_value_d = wdata_i;
        end else if (timer_tick) begin
            if (is_pc) begin
                count_value_d = next_down ? count_value_q - 8'h01 : count_value_q + 8'h01;
            end else if (at_top && top_is_a) begin
                count_value_d = `ETM_BOTTOM;
            end else if (is_fast && at_top) begin
                count_value_d = `ETM_BOTTOM;
            end else begin
                count_value_d = count_value_q + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Events and flags
    // ---------------------------------------------------------------
    etm_evt_s evt;
    assign evt.ovf     = timer_tick && (is_pc ? at_bottom && dir_down_q
                         : (is_fast && top_is_a ? at_top : at_max));
    assign evt.match_a = timer_tick && !block_q && match_a;
    assign evt.match_b = timer_tick && !block_q && match_b;
    wire [2:0] evt_v = {evt.match_b, evt.match_a, evt.ovf};
    wire [2:0] ack_v = {ack_match_b_i, ack_match_a_i, ack_ovf_i};
    wire [2:0] clr_v = (wr_flags ? wdata_i[2:0] : 3'h0) | ack_v;

    assign timer_irq_flags_d = (timer_irq_flags_q & ~clr_v) | evt_v;
    wire [2:0] irq_v = timer_irq_flags_q & timer_irq_mask_q;
    assign irq_ovf_o     = irq_v[`ETM_BIT_OVF];
    assign irq_match_a_o = irq_v[`ETM_BIT_MATCH_A];
    assign irq_match_b_o = irq_v[`ETM_BIT_MATCH_B];

    // Buffered compare values load at top (pc) or bottom (fast); direct otherwise
    wire cmp_load = !is_pwm || (timer_tick && (is_pc ? at_top && !dir_down_q : at_top));

    // ---------------------------------------------------------------
    // Waveform generator
    // ---------------------------------------------------------------
    function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                       input logic hit, input logic up, input logic pwm);
        logic r;
        r = cur;
        if (hit) begin
            unique case (com)
                2'b00: r = cur;
                2'b01: r = pwm ? cur : !cur;
                2'b10: r = pwm ? !up : 1'b0;
                2'b11: r = pwm ? up : 1'b1;
            endcase
        end
        wave_next = r;
    endfunction : wave_next

    wire up_now   = !dir_down_q;
    wire fast_bot = is_fast && timer_tick && at_top;
    wire hit_a    = evt.match_a || (force_a && !is_pwm);
    wire hit_b    = evt.match_b || (force_b && !is_pwm);
    wire wave_a_d = fast_bot && com_a[1] ? !com_a[0]
                  : wave_next(wave_a_q, com_a, hit_a, up_now, is_pwm);
    wire wave_b_d = fast_bot && com_b[1] ? !com_b[0]
                  : wave_next(wave_b_q, com_b, hit_b, up_now, is_pwm);

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus.addr)
            `ETM_OFS_CTRL_A:    rd_mux = ctrl_a_q;
            `ETM_OFS_CTRL_B:    rd_mux = {2'b00, timer_control_b_q[5:0]};
            `ETM_OFS_COUNT:     rd_mux = count_value_q;
            `ETM_OFS_CMP_A:     rd_mux = is_pwm ? buf_a_q : compare_value_a_q;
            `ETM_OFS_CMP_B:     rd_mux = is_pwm ? buf_b_q : compare_value_b_q;
            `ETM_OFS_IRQ_MASK:  rd_mux = {5'h00, timer_irq_mask_q};
            `ETM_OFS_IRQ_FLAGS: rd_mux = {5'h00, timer_irq_flags_q};
            `ETM_OFS_STATUS:    rd_mux = {5'h00, dir_down_q, wave_b_q, wave_a_q};
            default:            rd_mux = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_a_q          <= `ETM_RESET_BYTE;
            timer_control_b_q <= `ETM_RESET_BYTE;
            count_value_q     <= `ETM_RESET_BYTE;
            compare_value_a_q <= `ETM_RESET_BYTE;
            compare_value_b_q <= `ETM_RESET_BYTE;
            buf_a_q           <= `ETM_RESET_BYTE;
            buf_b_q           <= `ETM_RESET_BYTE;
            timer_irq_mask_q  <= 3'h0;
            timer_irq_flags_q <= 3'h0;
            rdata_q           <= 8'h00;
            presc_q           <= '0;
            ext_q             <= 1'b0;
            dir_down_q        <= 1'b0;
            block_q           <= 1'b0;
            wave_a_q          <= 1'b0;
            wave_b_q          <= 1'b0;
        end else begin
            if (wr_ctrl_a) ctrl_a_q <= wdata_i;
            if (wr_ctrl_b) timer_control_b_q <= {2'b00, wdata_i[5:0]};
            if (wr_mask) timer_irq_mask_q <= wdata_i[2:0];
            if (wr_cmp_a) buf_a_q <= wdata_i;
            if (wr_cmp_b) buf_b_q <= wdata_i;
            if (cmp_load) compare_value_a_q <= wr_cmp_a && !is_pwm ? wdata_i : buf_a_q;
            if (cmp_load) compare_value_b_q <= wr_cmp_b && !is_pwm ? wdata_i : buf_b_q;
            count_value_q     <= count_value_d;
            timer_irq_flags_q <= timer_irq_flags_d;
            // Write blocks the match of the next tick only, even while stopped
            block_q           <= wr_count || (block_q && !timer_tick);
            if (timer_tick && !wr_count) dir_down_q <= next_down;
            if (!is_pc) dir_down_q <= 1'b0;
            presc_q           <= presc_q + `ETM_PRESC_W'(1);
            ext_q             <= ext_count_pin_i;
            wave_a_q          <= wave_a_d;
            wave_b_q          <= wave_b_d;
            rdata_q           <= bus.rd ? rd_mux : 8'h00;
        end
    end

    assign rdata_o      = rdata_q;
    assign wave_out_a_o = wave_a_q;
    assign wave_out_b_o = wave_b_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    count_write_wins_a: assert property (wr_count |=> count_value_q == $past(wdata_i))
        else $error("count write lost");

    stopped_holds_a: assert property (clock_select_field == ETM_CS_STOP && !wr_count
        |=> $stable(count_value_q))
        else $error("counter moved while stopped");

    match_a_flag_a: assert property (evt.match_a |=> timer_irq_flags_q[`ETM_BIT_MATCH_A])
        else $error("match A flag not set");

    match_b_flag_a: assert property (evt.match_b |=> timer_irq_flags_q[`ETM_BIT_MATCH_B])
        else $error("match B flag not set");

    flag_clear_a: assert property (wr_flags && wdata_i[0] && !evt.ovf && !ack_ovf_i
        |=> !timer_irq_flags_q[`ETM_BIT_OVF])
        else $error("flag write-one clear failed");

    irq_gate_a: assert property (irq_ovf_o == (timer_irq_flags_q[0] && timer_irq_mask_q[0]))
        else $error("interrupt not gated by mask");

    ctc_clear_a: assert property (wgm == ETM_WG_CTC && timer_tick && at_top && !wr_count
        |=> count_value_q == `ETM_BOTTOM)
        else $error("clear on match failed");

    normal_wrap_a: assert property (wgm == ETM_WG_NORMAL && timer_tick && at_max && !wr_count
        |=> count_value_q == `ETM_BOTTOM && timer_irq_flags_q[`ETM_BIT_OVF])
        else $error("overflow wrap failed");

    // ---------------------------------------------------------------
    // Further checks, several built on multi-step sequences
    // ---------------------------------------------------------------
    // Edge detect compares with the previous sample, so one level change is one tick
    sequence ext_rise_s;
        clock_select_field == ETM_CS_EXT_RISE && !ext_count_pin_i
        ##1 clock_select_field == ETM_CS_EXT_RISE && ext_count_pin_i;
    endsequence

    sequence ext_fall_s;
        clock_select_field == ETM_CS_EXT_FALL && ext_count_pin_i
        ##1 clock_select_field == ETM_CS_EXT_FALL && !ext_count_pin_i;
    endsequence

    sequence count_write_s;
        wr_count ##1 timer_tick;
    endsequence

    sequence pc_peak_s;
        is_pc && timer_tick && !wr_count && at_top && !dir_down_q;
    endsequence

    sequence pc_floor_s;
        is_pc && timer_tick && !wr_count && at_bottom && dir_down_q;
    endsequence

    ext_rise_a: assert property (ext_rise_s |-> timer_tick)
        else $error("rising edge missed");

    ext_fall_a: assert property (ext_fall_s |-> timer_tick)
        else $error("falling edge missed");

    write_blocks_a: assert property (count_write_s |-> !evt.match_a && !evt.match_b)
        else $error("match not blocked after count write");

    pc_turn_a: assert property (pc_peak_s |=> dir_down_q)
        else $error("no turn at top");

    pc_bottom_a: assert property (pc_floor_s
        |=> !dir_down_q && timer_irq_flags_q[`ETM_BIT_OVF])
        else $error("no turn or overflow at bottom");

    stop_no_tick_a: assert property (clock_select_field == ETM_CS_STOP |-> !timer_tick)
        else $error("tick while stopped");

    div1_tick_a: assert property (clock_select_field == ETM_CS_DIV1 |-> timer_tick)
        else $error("undivided tick missing");

    count_hold_a: assert property (!timer_tick && !wr_count |=> $stable(count_value_q))
        else $error("counter moved without tick");

    fast_wrap_a: assert property (is_fast && timer_tick && at_top && !wr_count
        |=> count_value_q == `ETM_BOTTOM)
        else $error("fast mode did not wrap at top");

    direct_load_a: assert property (!is_pwm && wr_cmp_a
        |=> compare_value_a_q == $past(wdata_i))
        else $error("direct compare write lost");

    // Buffered writes must not reach the comparator mid-period
    pwm_buffer_a: assert property (is_pwm && wr_cmp_b && !cmp_load
        |=> buf_b_q == $past(wdata_i) && $stable(compare_value_b_q))
        else $error("buffered compare leaked");

    ack_clear_a: assert property (ack_match_a_i && !evt.match_a
        |=> !timer_irq_flags_q[`ETM_BIT_MATCH_A])
        else $error("service did not clear match A");

    ovf_ack_a: assert property (ack_ovf_i && !evt.ovf
        |=> !timer_irq_flags_q[`ETM_BIT_OVF])
        else $error("service did not clear overflow");

    set_wins_a: assert property (evt.match_b && ack_match_b_i
        |=> timer_irq_flags_q[`ETM_BIT_MATCH_B])
        else $error("clear beat a new match");

    irq_gate_ma_a: assert property (irq_match_a_o
        == (timer_irq_flags_q[1] && timer_irq_mask_q[1]))
        else $error("match A request not gated");

    irq_gate_mb_a: assert property (irq_match_b_o
        == (timer_irq_flags_q[2] && timer_irq_mask_q[2]))
        else $error("match B request not gated");

    force_wave_a: assert property (force_a && !is_pwm && com_a == 2'b01 && !evt.match_a
        |=> wave_a_q != $past(wave_a_q))
        else $error("forced compare did not toggle");

    read_data_a: assert property (rd_i && addr_i == `ETM_OFS_COUNT
        |=> rdata_o == $past(count_value_q))
        else $error("count read wrong");

    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");

endmodule : etm_timer

// ==== bench/etm_timer_test.sv ====
`include "etm_regs.svh"

module etm_timer_test
    import etm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk_i;
    logic       reset_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       ext_count_pin_i;
    logic       ack_ovf_i;
    logic       ack_match_a_i;
    logic       ack_match_b_i;
    logic       irq_ovf_o;
    logic       irq_match_a_o;
    logic       irq_match_b_o;
    logic       wave_out_a_o;
    logic       wave_out_b_o;
    int         miscompares;
    int         checked;
    int         cycles;

    etm_timer u_etm_timer (
        .sys_clk_i       (sys_clk_i),
        .reset_i         (reset_i),
        .addr_i          (addr_i),
        .wdata_i         (wdata_i),
        .wr_i            (wr_i),
        .rd_i            (rd_i),
        .rdata_o         (rdata_o),
        .ext_count_pin_i (ext_count_pin_i),
        .ack_ovf_i       (ack_ovf_i),
        .ack_match_a_i   (ack_match_a_i),
        .ack_match_b_i   (ack_match_b_i),
        .irq_ovf_o       (irq_ovf_o),
        .irq_match_a_o   (irq_match_a_o),
        .irq_match_b_o   (irq_match_b_o),
        .wave_out_a_o    (wave_out_a_o),
        .wave_out_b_o    (wave_out_b_o)
    );

    // ----------------------------------------------------------------
    // Clock and run limit
    // ----------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Whole sequence needs well under 2000 cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] msk);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o & msk, exp);
    endtask : rd

    // Pin held at least two cycles each level so the synchronous sampler sees every edge
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            ext_count_pin_i <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            ext_count_pin_i <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
        end
        repeat (6) @(posedge sys_clk_i);
    endtask : pulses

    task automatic ack(input int which);
        @(posedge sys_clk_i);
        ack_match_a_i <= (which == 1);
        ack_match_b_i <= (which == 2);
        @(posedge sys_clk_i);
        ack_match_a_i <= 1'b0;
        ack_match_b_i <= 1'b0;
        #1;
    endtask : ack

    task automatic run_div1(input logic [7:0] start, input int n);
        wr(`ETM_OFS_COUNT, start);
        wr(`ETM_OFS_CTRL_B, 8'h01);
        repeat (n) @(posedge sys_clk_i);
        wr(`ETM_OFS_CTRL_B, 8'h00);
    endtask : run_div1

    task automatic close_out();
        $display("checks made %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        miscompares = 0;
        checked = 0;
        cycles = 0;
        reset_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        ext_count_pin_i = 1'b0;
        ack_ovf_i = 1'b0;
        ack_match_a_i = 1'b0;
        ack_match_b_i = 1'b0;
        repeat (12) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, 8'hFF);
        $display("test reset values done");

        wr(`ETM_OFS_COUNT, 8'h5A);
        rd(`ETM_OFS_COUNT, 8'h5A, 8'hFF);
        wr(`ETM_OFS_CTRL_B, 8'h07);
        pulses(4);
        wr(`ETM_OFS_CTRL_B, 8'h00);
        rd(`ETM_OFS_COUNT, 8'h5E, 8'hFF);
        wr(`ETM_OFS_CTRL_B, 8'h06);
        pulses(3);
        wr(`ETM_OFS_CTRL_B, 8'h00);
        rd(`ETM_OFS_COUNT, 8'h61, 8'hFF);
        pulses(3);
        rd(`ETM_OFS_COUNT, 8'h61, 8'hFF);
        $display("test clock sources done");

        wr(`ETM_OFS_CMP_A, 8'hC8);
        wr(`ETM_OFS_CMP_B, 8'h63);
        wr(`ETM_OFS_CTRL_B, 8'h07);
        pulses(4);
        wr(`ETM_OFS_CTRL_B, 8'h00);
        rd(`ETM_OFS_IRQ_FLAGS, 8'h04, 8'hFF);
        chk(irq_match_b_o, 1'b0);
        wr(`ETM_OFS_IRQ_MASK, 8'h04);
        #1;
        chk(irq_match_b_o, 1'b1);
        ack(2);
        chk(irq_match_b_o, 1'b0);
        rd(`ETM_OFS_IRQ_FLAGS, 8'h00, 8'hFF);
        $display("test match b done");

        run_div1(8'hFD, 20);
        rd(`ETM_OFS_IRQ_FLAGS, 8'h01, 8'hFF);
        wr(`ETM_OFS_IRQ_MASK, 8'h01);
        #1;
        chk(irq_ovf_o, 1'b1);
        wr(`ETM_OFS_IRQ_FLAGS, 8'h01);
        #1;
        chk(irq_ovf_o, 1'b0);
        rd(`ETM_OFS_IRQ_FLAGS, 8'h00, 8'hFF);
        $display("test overflow done");

        run_div1(8'hC0, 20);
        rd(`ETM_OFS_IRQ_FLAGS, 8'h02, 8'hFF);
        wr(`ETM_OFS_IRQ_MASK, 8'h02);
        #1;
        chk(irq_match_a_o, 1'b1);
        ack(1);
        chk(irq_match_a_o, 1'b0);
        $display("test match a done");

        wr(`ETM_OFS_CMP_A, 8'h10);
        wr(`ETM_OFS_CTRL_A, 8'h02);
        wr(`ETM_OFS_COUNT, 8'h00);
        wr(`ETM_OFS_CTRL_B, 8'h01);
        repeat (30) begin
            rd(`ETM_OFS_COUNT, 8'h00, 8'hE0);
        end
        wr(`ETM_OFS_CTRL_B, 8'h00);
        $display("test clear on match done");

        wr(`ETM_OFS_CTRL_A, 8'h01);
        run_div1(8'hF0, 30);
        rd(`ETM_OFS_STATUS, 8'h04, 8'h04);
        $display("test phase correct done");

        wr(`ETM_OFS_CTRL_A, 8'h40);
        wr(`ETM_OFS_CTRL_B, 8'h80);
        #1;
        chk(wave_out_a_o, 1'b1);
        chk(wave_out_b_o, 1'b0);
        rd(`ETM_OFS_CTRL_B, 8'h00, 8'hC0);
        wr(`ETM_OFS_CTRL_B, 8'h80);
        #1;
        chk(wave_out_a_o, 1'b0);
        $display("test forced compare done");
        close_out();
    end

endmodule : etm_timer_test
